//--- hw/wdit_top.v
// Watchdog and interval timer with a classic Wishbone register slave.
// Assumes clk_i is the main system clock and standby inputs are synchronous.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "wdit_regs.vh"

// What this block does
// - Count clock is main clock divided per select
// - Run write clears counter and starts counting
// - Run bit cannot be cleared by software
// - Mode bits choose stop, interval, NMI, reset
// - Mode bits stick once set until reset
// - Interval mode times after run, repeats interrupts
// - Prescaler kept on restart, first overflow early
// - Flag already set gives NMI on NMI mode write
// - Watchdog overflow resets or raises NMI
// - Counts in HALT, stops in STOP
// - No counting while CPU runs on subclock
// - Interval interrupt gated by its mask flag
// - Reset clears select and mode registers
module wdit_top
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [15:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Standby and clock state
	input  wire        stop_mode_i,
	input  wire        sub_clock_cpu_i,
	// Events
	output reg         nmi_o,
	output reg         reset_req_o,
	output reg         irq_o
);

	reg  [7:0]                 clock_select_q;
	reg  [7:0]                 mode_control_q;
	reg  [7:0]                 irq_status_q;
	reg  [7:0]                 irq_mask_q;
	reg  [`WDIT_CNT_WIDTH-1:0] count_q;
	reg                        wr_run_q;
	wire                       tick;
	wire                       count_en;
	wire                       overflow;
	wire                       access;
	wire                       wr;
	wire                       mode_sel_wr;
	wire [1:0]                 mode;
	wire [7:0]                 wd;
	wire [7:0]                 st_set;
	reg  [7:0]                 rd_data;

	// Byte lane decode by index: byte address = 4 * index
	function [15:0] reg_idx;
		input [15:0] adr;
		begin
			reg_idx = {2'b00, adr[15:2]};
		end
	endfunction

	function is_reg;
		input [15:0] adr;
		input [15:0] idx;
		begin
			is_reg = (reg_idx(adr) == (idx & 16'h3fff)) && (adr[1:0] == 2'b00);
		end
	endfunction

	// Only four 16-bit byte addresses fit; the index keeps its low 14 bits
	assign access = cyc_i & stb_i & ~ack_o;
	assign wr     = access & we_i & sel_i[0];
	assign wd     = dat_i[7:0];
	assign mode   = {mode_control_q[`WDIT_MODE_HIGH_BIT], mode_control_q[`WDIT_MODE_LOW_BIT]};

	// Counting needs run, a mode, main clock driving the CPU, and no STOP
	assign count_en = mode_control_q[`WDIT_RUN_BIT] & (mode != `WDIT_MODE_STOP) & ~stop_mode_i
		& ~sub_clock_cpu_i;

	wdit_prescaler u_prescaler
	(
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.enable_i       (count_en),
		.clock_select_i ({clock_select_q[`WDIT_CS_HIGH_BIT], clock_select_q[`WDIT_CS_LOW_BIT]}),
		.tick_o         (tick)
	);

	assign overflow = tick & count_en & (count_q == `WDIT_CNT_LAST);

	// Register writes
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clock_select_q <= `WDIT_CS_RESET;
			mode_control_q <= `WDIT_MODE_RESET;
			irq_mask_q     <= `WDIT_MASK_RESET;
			wr_run_q       <= 1'b0;
		end
		else
		begin
			wr_run_q <= wr & is_reg(adr_i, `WDIT_IDX_MODE_CONTROL) & wd[`WDIT_RUN_BIT];
			if (wr && is_reg(adr_i, `WDIT_IDX_CLOCK_SELECT))
				clock_select_q <= wd & `WDIT_CS_WMASK;
			// Only sets are taken: run and mode bits are sticky
			if (wr && is_reg(adr_i, `WDIT_IDX_MODE_CONTROL))
				mode_control_q <= mode_control_q | (wd & `WDIT_MODE_WMASK);
			if (wr && is_reg(adr_i, `WDIT_IDX_IRQ_MASK))
				irq_mask_q <= wd & `WDIT_ST_WMASK;
		end
	end

	// Counter: restart clears it only, the prescaler runs on
	always @(posedge clk_i)
	begin
		if (rst_i)
			count_q <= {`WDIT_CNT_WIDTH{1'b0}};
		else if (wr_run_q)
			count_q <= {`WDIT_CNT_WIDTH{1'b0}};
		else if (tick && count_en)
			count_q <= count_q + 1'b1;
	end

	// Status: bit 0 watchdog flag, bit 1 interval flag; set beats write-one clear
	assign st_set = {6'h00, overflow & (mode == `WDIT_MODE_INTERVAL), overflow & mode[1]};

	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_status_q <= `WDIT_ST_RESET;
		else if (wr && is_reg(adr_i, `WDIT_IDX_IRQ_STATUS))
			irq_status_q <= (irq_status_q & ~(wd & `WDIT_ST_WMASK)) | st_set;
		else
			irq_status_q <= irq_status_q | st_set;
	end

	// Event outputs
	assign mode_sel_wr = wr & is_reg(adr_i, `WDIT_IDX_MODE_CONTROL) & wd[`WDIT_MODE_HIGH_BIT];

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nmi_o       <= 1'b0;
			reset_req_o <= 1'b0;
			irq_o       <= 1'b0;
		end
		else
		begin
			// NMI pulse on overflow in mode 2, or a pending watchdog flag when a write selects the NMI mode
			nmi_o <= (overflow & (mode == `WDIT_MODE_NMI))
				| (mode_sel_wr & ~wd[`WDIT_MODE_LOW_BIT] & ~mode[0]
				& irq_status_q[`WDIT_ST_WDT_BIT]);
			reset_req_o <= overflow & (mode == `WDIT_MODE_RESET_OUT);
			irq_o <= |(irq_status_q & irq_mask_q & 8'h02);
		end
	end

	// Read mux
	always @*
	begin
		rd_data = 8'h00;
		if (is_reg(adr_i, `WDIT_IDX_CLOCK_SELECT))
			rd_data = clock_select_q;
		else if (is_reg(adr_i, `WDIT_IDX_MODE_CONTROL))
			rd_data = mode_control_q;
		else if (is_reg(adr_i, `WDIT_IDX_IRQ_STATUS))
			rd_data = irq_status_q;
		else if (is_reg(adr_i, `WDIT_IDX_IRQ_MASK))
			rd_data = irq_mask_q;
	end

	// One wait-free ack per access; unmapped reads give zero, writes are dropped
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= access;
			dat_o <= access ? {24'h000000, rd_data} : 32'h00000000;
		end
	end

endmodule // wdit_top

//--- hw/wdit_regs.vh
// Register map, field positions, reset values and timing counts of the watchdog interval timer.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
`ifndef WDIT_REGS_VH
`define WDIT_REGS_VH

// Printed offsets are not all multiples of four: they are register indices
`define WDIT_IDX_CLOCK_SELECT   16'hff42
`define WDIT_IDX_MODE_CONTROL   16'hfff9
`define WDIT_IDX_IRQ_STATUS     16'hff00
`define WDIT_IDX_IRQ_MASK       16'hff01

// Clock-select fields
`define WDIT_CS_LOW_BIT         1
`define WDIT_CS_HIGH_BIT        2
`define WDIT_CS_WMASK           8'h06

// Mode-control fields
`define WDIT_MODE_LOW_BIT       3
`define WDIT_MODE_HIGH_BIT      4
`define WDIT_RUN_BIT            7
`define WDIT_MODE_WMASK         8'h98

// Status and mask fields
`define WDIT_ST_WDT_BIT         0
`define WDIT_ST_ITV_BIT         1
`define WDIT_ST_WMASK           8'h03

// Reset values
`define WDIT_CS_RESET           8'h00
`define WDIT_MODE_RESET         8'h00
`define WDIT_ST_RESET           8'h00
`define WDIT_MASK_RESET         8'h00

// Prescaler divide exponents 4, 6, 8, 10: ratios 16, 64, 256, 1024
`define WDIT_DIV_EXP0           4
`define WDIT_DIV_EXP1           6
`define WDIT_DIV_EXP2           8
`define WDIT_DIV_EXP3           10
`define WDIT_PRE_WIDTH          10
// Count clocks to overflow: 2^7
`define WDIT_CNT_WIDTH          7
`define WDIT_CNT_LAST           7'h7f

// Mode encodings
`define WDIT_MODE_STOP          2'b00
`define WDIT_MODE_INTERVAL      2'b01
`define WDIT_MODE_NMI           2'b10
`define WDIT_MODE_RESET_OUT     2'b11

`endif

//--- hw/wdit_prescaler.v
// Enable-gated main-clock prescaler producing a one-cycle count-clock tick.
// Assumes clk_i is the main system clock; the prescaler is never cleared by a restart.
`timescale 1ns/1ps
`include "wdit_regs.vh"

module wdit_prescaler
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Control
	input  wire       enable_i,
	input  wire [1:0] clock_select_i,
	// Tick out
	output reg        tick_o
);

	reg [`WDIT_PRE_WIDTH-1:0] pre_q;
	reg                       hit;

	always @(posedge clk_i)
	begin
		if (rst_i)
			pre_q <= {`WDIT_PRE_WIDTH{1'b0}};
		else if (enable_i)
			pre_q <= pre_q + 1'b1;
	end

	// Tick when the low exponent bits all wrap to zero
	always @*
	begin
		case (clock_select_i)
			2'b00:   hit = (pre_q[`WDIT_DIV_EXP0-1:0] == {`WDIT_DIV_EXP0{1'b1}});
			2'b01:   hit = (pre_q[`WDIT_DIV_EXP1-1:0] == {`WDIT_DIV_EXP1{1'b1}});
			2'b10:   hit = (pre_q[`WDIT_DIV_EXP2-1:0] == {`WDIT_DIV_EXP2{1'b1}});
			default: hit = (pre_q[`WDIT_DIV_EXP3-1:0] == {`WDIT_DIV_EXP3{1'b1}});
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			tick_o <= 1'b0;
		else
			tick_o <= enable_i & hit;
	end

endmodule // wdit_prescaler

//--- verification/wdit_asserts.sv
// Port checker for the watchdog interval timer.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
module wdit_asserts
(
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Bus and events
	input wire        cyc_i,
	input wire        stb_i,
	input wire [15:0] adr_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        stop_mode_i,
	input wire        nmi_o,
	input wire        reset_req_o,
	input wire        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence acc_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	ack_once_a: assert property (acc_s |=> ack_o ##1 !ack_o) else $error("ack timing");
	cs_bits_a: assert property (ack_o && adr_i == 16'hfd08 |-> (dat_o & 32'hfffffff9) == 32'h0)
		else $error("clock select spare bits");
	mode_bits_a: assert property (ack_o && adr_i == 16'hffe4 |-> (dat_o & 32'hffffff67) == 32'h0)
		else $error("mode spare bits");
	nmi_pulse_a: assert property (nmi_o |=> !nmi_o) else $error("nmi width");
	rst_pulse_a: assert property (reset_req_o |=> !reset_req_o) else $error("reset width");
	one_event_a: assert property (!(nmi_o && reset_req_o)) else $error("two events");
	// Three cycles of STOP let any overflow already in flight drain out
	stop_hold_a: assert property (stop_mode_i [*3] |-> !nmi_o && !reset_req_o) else $error("count in stop");
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !irq_o && !nmi_o && !ack_o)
		else $error("reset outputs");
endmodule // wdit_asserts

bind wdit_top wdit_asserts u_wdit_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o,
	.stop_mode_i, .nmi_o, .reset_req_o, .irq_o);

//--- verification/testbench.sv
// Self-checking bench for the watchdog interval timer.
// Assumes the byte-address map of the Wishbone slave.
`timescale 1ns/1ps
module testbench;
	localparam [15:0] CS = 16'hfd08, MD = 16'hffe4, ST = 16'hfc00, MK = 16'hfc04;
	reg        clk_i = 1'b0;
	reg        rst_i = 1'b1;
	reg        cyc_i = 1'b0;
	reg        stb_i = 1'b0;
	reg        we_i = 1'b0;
	reg [15:0] adr_i = 16'h0;
	reg [31:0] dat_i = 32'h0;
	reg        stop_mode_i = 1'b0;
	reg        sub_clock_cpu_i = 1'b0;
	wire [31:0] dat_o;
	wire       ack_o, nmi_o, reset_req_o, irq_o;
	wire [2:0] ev = {reset_req_o, nmi_o, irq_o};
	reg [31:0] q;
	int        mismatches = 0, n_compared = 0, n, t1, cycles = 0, nmi_cnt = 0;
	wdit_top u_wdit_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o,
		.ack_o, .stop_mode_i, .sub_clock_cpu_i, .nmi_o, .reset_req_o, .irq_o);
	initial forever #2.5 clk_i = ~clk_i;
	task results;
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		// NMI pulses stand one cycle, so they are counted here rather than polled
		if (nmi_o === 1'b1)
			nmi_cnt <= nmi_cnt + 1;
		if (cycles == 60000)
		begin
			mismatches = mismatches + 1;
			results;
		end
	end
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Entered just after a rising edge; leaves one idle cycle before the next access
	task wb(input w, input [15:0] a, input [31:0] d);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task waitfor(input int s, input int lim);
		n = 0;
		while (n < lim && ev[s] !== 1'b1)
		begin
			@(posedge clk_i);
			n = n + 1;
		end
	endtask
	task do_reset;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task t_regs;
		wb(1'b0, CS, 0);
		chk("cs rst", q, 0);
		wb(1'b0, MD, 0);
		chk("md rst", q, 0);
		wb(1'b0, 16'h0010, 0);
		chk("unmapped", q, 0);
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b1, CS, 32'hf9 | (i << 1));
			wb(1'b0, CS, 0);
			chk("cs", q, i << 1);
		end
	endtask
	task t_interval;
		wb(1'b1, CS, 0);
		wb(1'b1, MK, 2);
		wb(1'b1, MD, 32'h6f);
		wb(1'b0, MD, 0);
		chk("md", q, 32'h08);
		waitfor(0, 2200);
		chk("no run", n, 2200);
		wb(1'b1, MD, 32'h80);
		waitfor(0, 2100);
		chk("first", n >= 2020 && n <= 2056, 1);
		t1 = cycles;
		wb(1'b1, ST, 2);
		repeat (2) @(posedge clk_i);
		chk("clr", irq_o, 0);
		waitfor(0, 2100);
		chk("period", cycles - t1, 2048);
		wb(1'b1, MK, 0);
		repeat (2) @(posedge clk_i);
		chk("mask", irq_o, 0);
		wb(1'b1, MD, 0);
		wb(1'b0, MD, 0);
		chk("sticky", q, 32'h88);
	endtask
	task t_nmi;
		wb(1'b1, MD, 32'h90);
		repeat (3)
		begin
			waitfor(1, 1500);
			chk("kick", n, 1500);
			wb(1'b1, MD, 32'h80);
		end
		stop_mode_i <= 1'b1;
		waitfor(1, 3000);
		chk("stop", n, 3000);
		stop_mode_i <= 1'b0;
		sub_clock_cpu_i <= 1'b1;
		waitfor(1, 3000);
		chk("sub", n, 3000);
		sub_clock_cpu_i <= 1'b0;
		waitfor(1, 2100);
		chk("nmi", n >= 2020 && n <= 2056, 1);
		wb(1'b0, ST, 0);
		chk("flag", q & 32'h1, 1);
		// The pulse comes and goes inside the access, so it is counted, not polled
		t1 = nmi_cnt;
		wb(1'b1, MD, 32'h10);
		chk("nmi write", nmi_cnt - t1, 1);
	endtask
	task t_wreset;
		wb(1'b1, CS, 2);
		wb(1'b1, MD, 32'h80);
		waitfor(2, 9000);
		chk("mode stop", n, 9000);
		wb(1'b1, MD, 32'h18);
		waitfor(2, 8300);
		chk("reset", n >= 8100 && n <= 8200, 1);
	endtask
	initial
	begin
		do_reset;
		t_regs;
		t_interval;
		do_reset;
		t_nmi;
		do_reset;
		t_wreset;
		results;
	end
endmodule // testbench
